// >>> inc/mic_pkg.sv
// Purpose: Shared constants for the interrupt controller
// Assumes: 8-bit registers on a 32-bit AXI4-Lite word each
// Notes:   Sources are indexed for priority and vector tables
package mic_pkg;
  localparam int           AXI_AW      = 8;
  localparam logic [7:0]   OFS_EDGE    = 8'h00;
  localparam logic [7:0]   OFS_CTRL0   = 8'h04;
  localparam logic [7:0]   OFS_CTRL1   = 8'h08;
  localparam logic [7:0]   OFS_STD     = 8'h0c;
  localparam logic [7:0]   OFS_PER     = 8'h10;
  localparam logic [7:0]   REG_RST     = 8'h00;
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;
  // Control register 0 fields
  localparam int           C0_GIE      = 0;
  localparam int           C0_EXT0E    = 1;
  localparam int           C0_MFE      = 2;
  localparam int           C0_EXT0F    = 4;
  localparam int           C0_MFF      = 5;
  // Control register 1 fields
  localparam int           C1_EXT1E    = 2;
  localparam int           C1_ADE      = 3;
  localparam int           C1_EXT1F    = 6;
  localparam int           C1_ADF      = 7;
  // Timer group register fields, {A,P} pairs
  localparam int           TM_EN       = 0;
  localparam int           TM_FLAG     = 4;
  // Edge select field
  localparam int           EDGE_W      = 2;
  localparam logic [1:0]   EDGE_OFF    = 2'h0;
  localparam logic [1:0]   EDGE_RISE   = 2'h1;
  localparam logic [1:0]   EDGE_FALL   = 2'h2;
  localparam logic [1:0]   EDGE_BOTH   = 2'h3;
  // Sources
  localparam int           NSRC        = 5;
  localparam int           SRC_W       = 3;
  localparam logic [2:0]   SRC_EXT0    = 3'h0;
  localparam logic [2:0]   SRC_EXT1    = 3'h1;
  localparam logic [2:0]   SRC_MF0     = 3'h2;
  localparam logic [2:0]   SRC_MF1     = 3'h3;
  localparam logic [2:0]   SRC_ADC     = 3'h4;
  localparam int           PC_W_DEF    = 12;
  // Slot 0 (low bits) is the highest priority
  localparam logic [14:0]  PRIO_DEF    = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [59:0]  VEC_DEF     = {12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};
endpackage

// >>> inc/mic_edge_if.sv
// Purpose: Link between controller and one pin edge detector
// Assumes: Same clock on both sides
// Notes:   evt is a one-cycle pulse
`timescale 1ns/1ps
interface mic_edge_if;
  logic [1:0] sel;
  logic       active;
  logic       evt;
  modport ctl (output sel, output active, input evt);
  modport det (input sel, input active, output evt);
endinterface

// >>> core/mic_edge_det.sv
// Purpose: Synchronise one pin and detect the selected edge
// Assumes: Pin is asynchronous to clk
// Notes:   One pulse per qualifying edge
`timescale 1ns/1ps
module mic_edge_det
  import mic_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  mic_edge_if.det   bus
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic evt;
  } mic_edge_state_t;

  mic_edge_state_t st;
  mic_edge_state_t next_st;
  logic            rise;
  logic            fall;

  always_comb begin
    next_st       = st;
    next_st.sync1 = pin;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    rise          = st.sync2 & ~st.prev;
    fall          = ~st.sync2 & st.prev;
    // Bit 0 of the field picks rising, bit 1 falling
    next_st.evt   = bus.active & ((bus.sel[0] & rise) | (bus.sel[1] & fall));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.evt = st.evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EDGE_OFF: assert property ($past(bus.sel) == EDGE_OFF |-> !bus.evt)
    else $error("Event while edge select disabled");
  AST_EDGE_RISE: assert property (
    bus.active && bus.sel == EDGE_RISE && st.sync2 && !st.prev |=> bus.evt)
    else $error("Rising edge missed");
endmodule

// >>> core/mic_irq_ctrl.sv
// Purpose: Interrupt controller with AXI4-Lite registers
// Assumes: Core gives instruction boundaries and stack state
// Notes:   Flags set by hardware win over any clear
// Behaviour
// - Standard timer group register: A flag bit5, P flag bit4, enables bits1/0.
// - Periodic timer group register: same layout, other bits read zero.
// - Flags set on their event whatever the enable says.
// - A flag vectors only when its own enable is one.
// - Global enable at zero suppresses every interrupt.
// - On take, push next PC and load the source vector.
// - Return from interrupt pops the saved PC.
// - Taking any interrupt clears the global enable.
// - Blocked requests stay latched and are served later.
// - Full stack blocks every take until it is popped.
// - Simultaneous enabled requests resolve by fixed priority.
// - Any flag becoming set wakes the device.
// - Pin flag set on the edge chosen by its select field.
// - Pin vectors need global enable, pin enable, stack not full.
// - Pin counts only when function selected and direction is input.
// - Edge select offers rise, fall, both or disabled.
// - Serving a pin interrupt clears that pin flag.
// - Group flag set when any of its timer flags becomes set.
// - Serving a group clears only the group flag and global enable.
// - Converter flag set at conversion end; vectors with both enables.
// - Serving converter clears its flag and the global enable.
// - Edge codes: 00 off, 01 rise, 10 fall, 11 both.
// - Return from interrupt sets global enable again.
// - Group vectors need global, group and timer source enables.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int                     PC_W      = PC_W_DEF,
  parameter logic [NSRC*SRC_W-1:0]  PRIO      = PRIO_DEF,
  parameter logic [NSRC*PC_W-1:0]   VEC_TABLE = VEC_DEF
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [mic_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [mic_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [1:0]           ext_irq_pin,
  input  wire logic [1:0]           pin_func_sel,
  input  wire logic [1:0]           pin_dir_in,
  input  wire logic                 conv_done_evt,
  input  wire logic [1:0]           std_cmp_evt,
  input  wire logic [1:0]           per_cmp_evt,
  input  wire logic                 core_boundary,
  input  wire logic [PC_W-1:0]      core_next_pc,
  input  wire logic                 stack_full,
  input  wire logic                 core_return_from_irq,
  output logic                      irq_take,
  output logic [PC_W-1:0]           irq_vector,
  output logic                      stack_push,
  output logic [PC_W-1:0]           stack_push_pc,
  output logic                      stack_pop,
  output logic                      wake
);
  typedef struct packed {
    logic [3:0]      edge_sel;
    logic            gie;
    logic [1:0]      ext_en;
    logic [1:0]      ext_flag;
    logic [1:0]      mf_en;
    logic [1:0]      mf_flag;
    logic            adc_en;
    logic            adc_flag;
    logic [1:0]      std_en;
    logic [1:0]      std_flag;
    logic [1:0]      per_en;
    logic [1:0]      per_flag;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [7:0]      rdata;
    logic            take;
    logic [2:0]      src;
    logic [PC_W-1:0] vec;
    logic [PC_W-1:0] push_pc;
    logic            pop;
    logic            wake;
  } mic_state_t;

  mic_state_t      st;
  mic_state_t      next_st;
  logic [NSRC-1:0] req;
  logic [2:0]      win;
  logic            any_req;
  logic            grant;
  logic            wr_go;
  logic            rd_go;
  logic [1:0]      ext_evt;
  logic [7:0]      rd_val;
  logic            rd_hit;
  logic [9:0]      old_flags;
  logic [9:0]      new_flags;

  mic_edge_if edge_bus [2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign edge_bus[gi].sel    = st.edge_sel[gi*EDGE_W +: EDGE_W];
      assign edge_bus[gi].active = pin_func_sel[gi] & pin_dir_in[gi];
      assign ext_evt[gi]         = edge_bus[gi].evt;
      mic_edge_det u_det (
        .clk (clk),
        .rst (rst),
        .pin (ext_irq_pin[gi]),
        .bus (edge_bus[gi])
      );
    end
  endgenerate

  // Requests that may vector
  always_comb begin
    req           = '0;
    req[SRC_EXT0] = st.ext_flag[0] & st.ext_en[0];
    req[SRC_EXT1] = st.ext_flag[1] & st.ext_en[1];
    req[SRC_MF0]  = st.mf_flag[0] & st.mf_en[0] & |(st.std_flag & st.std_en);
    req[SRC_MF1]  = st.mf_flag[1] & st.mf_en[1] & |(st.per_flag & st.per_en);
    req[SRC_ADC]  = st.adc_flag & st.adc_en;
  end

  // Fixed priority pick, slot 0 wins
  always_comb begin
    win     = '0;
    any_req = |req;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (req[PRIO[k*SRC_W +: SRC_W]]) begin
        win = PRIO[k*SRC_W +: SRC_W];
      end
    end
  end

  assign grant = core_boundary & st.gie & ~stack_full & any_req;

  // Register readback
  always_comb begin
    rd_val = REG_RST;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_EDGE: begin
        rd_val = {4'h0, st.edge_sel};
      end
      OFS_CTRL0: begin
        rd_val = {1'b0, st.mf_flag, st.ext_flag[0], st.mf_en, st.ext_en[0], st.gie};
      end
      OFS_CTRL1: begin
        rd_val = {st.adc_flag, st.ext_flag[1], 2'h0, st.adc_en, st.ext_en[1], 2'h0};
      end
      OFS_STD: begin
        rd_val = {2'h0, st.std_flag, 2'h0, st.std_en};
      end
      OFS_PER: begin
        rd_val = {2'h0, st.per_flag, 2'h0, st.per_en};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st.bvalid;
  assign rd_go = s_axi_arvalid & ~st.rvalid;

  always_comb begin
    next_st      = st;
    next_st.take = 1'b0;
    next_st.pop  = 1'b0;
    // Write channel
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        OFS_EDGE: begin
          if (s_axi_wstrb[0]) begin
            next_st.edge_sel = s_axi_wdata[3:0];
          end
        end
        OFS_CTRL0: begin
          if (s_axi_wstrb[0]) begin
            next_st.gie       = s_axi_wdata[C0_GIE];
            next_st.ext_en[0] = s_axi_wdata[C0_EXT0E];
            next_st.mf_en     = s_axi_wdata[C0_MFE +: 2];
            next_st.ext_flag[0] = s_axi_wdata[C0_EXT0F];
            next_st.mf_flag   = s_axi_wdata[C0_MFF +: 2];
          end
        end
        OFS_CTRL1: begin
          if (s_axi_wstrb[0]) begin
            next_st.ext_en[1]   = s_axi_wdata[C1_EXT1E];
            next_st.adc_en      = s_axi_wdata[C1_ADE];
            next_st.ext_flag[1] = s_axi_wdata[C1_EXT1F];
            next_st.adc_flag    = s_axi_wdata[C1_ADF];
          end
        end
        OFS_STD: begin
          if (s_axi_wstrb[0]) begin
            next_st.std_en   = s_axi_wdata[TM_EN +: 2];
            next_st.std_flag = s_axi_wdata[TM_FLAG +: 2];
          end
        end
        OFS_PER: begin
          if (s_axi_wstrb[0]) begin
            next_st.per_en   = s_axi_wdata[TM_EN +: 2];
            next_st.per_flag = s_axi_wdata[TM_FLAG +: 2];
          end
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // Return from interrupt
    if (core_return_from_irq) begin
      next_st.pop = 1'b1;
      next_st.gie = 1'b1;
    end
    // Vector the core
    if (grant) begin
      next_st.take    = 1'b1;
      next_st.src     = win;
      next_st.vec     = VEC_TABLE[win*PC_W +: PC_W];
      next_st.push_pc = core_next_pc;
      next_st.gie     = 1'b0;
      case (win)
        SRC_EXT0: begin
          next_st.ext_flag[0] = 1'b0;
        end
        SRC_EXT1: begin
          next_st.ext_flag[1] = 1'b0;
        end
        SRC_MF0: begin
          next_st.mf_flag[0] = 1'b0;
        end
        SRC_MF1: begin
          next_st.mf_flag[1] = 1'b0;
        end
        SRC_ADC: begin
          next_st.adc_flag = 1'b0;
        end
        default: begin
          next_st.take = 1'b0;
        end
      endcase
    end
    // Hardware sets win over every clear
    next_st.ext_flag = next_st.ext_flag | ext_evt;
    next_st.adc_flag = next_st.adc_flag | conv_done_evt;
    next_st.std_flag = next_st.std_flag | std_cmp_evt;
    next_st.per_flag = next_st.per_flag | per_cmp_evt;
    if (|(next_st.std_flag & ~st.std_flag)) begin
      next_st.mf_flag[0] = 1'b1;
    end
    if (|(next_st.per_flag & ~st.per_flag)) begin
      next_st.mf_flag[1] = 1'b1;
    end
    old_flags    = {st.ext_flag, st.mf_flag, st.adc_flag, st.std_flag, st.per_flag, 1'b0};
    new_flags    = {next_st.ext_flag, next_st.mf_flag, next_st.adc_flag,
                    next_st.std_flag, next_st.per_flag, 1'b0};
    next_st.wake = |(new_flags & ~old_flags);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = {24'h000000, st.rdata};
  assign irq_take      = st.take;
  assign irq_vector    = st.vec;
  assign stack_push    = st.take;
  assign stack_push_pc = st.push_pc;
  assign stack_pop     = st.pop;
  assign wake          = st.wake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    irq_take;
  endsequence

  sequence s_timer_a_new;
    std_cmp_evt[1] && !st.std_flag[1];
  endsequence

  AST_GIE_GATES: assert property (s_take |-> $past(st.gie))
    else $error("Interrupt taken with global enable off");
  AST_GIE_CLEARED: assert property ((s_take and !$past(core_return_from_irq)) |-> !st.gie)
    else $error("Global enable not cleared on take");
  AST_STACK_FULL: assert property (s_take |-> !$past(stack_full))
    else $error("Interrupt taken with full stack");
  AST_PUSH_PC: assert property (s_take |-> stack_push && stack_push_pc == $past(core_next_pc))
    else $error("Pushed PC does not match next PC");
  AST_RETURN: assert property (core_return_from_irq |=> stack_pop && (st.gie || irq_take))
    else $error("Return did not pop or re-enable");
  AST_FLAG_SET: assert property (std_cmp_evt[1] |=> st.std_flag[1])
    else $error("Timer flag not set by its event");
  AST_GROUP_SET: assert property (s_timer_a_new |=> st.mf_flag[0] && wake)
    else $error("Group flag or wake missing");
  AST_ADC_EN: assert property ((s_take and (st.src == SRC_ADC)) |-> $past(st.adc_en))
    else $error("Converter taken while disabled");
  AST_ADC_CLEAR: assert property (
    (s_take and (st.src == SRC_ADC && !$past(conv_done_evt) && !$past(wr_go))) |-> !st.adc_flag)
    else $error("Converter flag not cleared on take");
  AST_EXT_PIN_CLEAR: assert property (
    (s_take and (st.src == SRC_EXT0 && !$past(ext_evt[0]) && !$past(wr_go))) |-> !st.ext_flag[0])
    else $error("Pin flag not cleared on take");
endmodule

// >>> testbench/mic_core_model.sv
// Purpose: Behavioural core sequencer with a small return stack
// Assumes: Core sits at an instruction boundary every cycle
// Notes:   Small depth so the full-stack case is reached
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int PC_W  = 12
)
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ret_req,
  input  wire logic            stack_push,
  input  wire logic [PC_W-1:0] stack_push_pc,
  input  wire logic            stack_pop,
  input  wire logic [PC_W-1:0] irq_vector,
  output logic                 core_boundary,
  output logic [PC_W-1:0]      core_next_pc,
  output logic                 stack_full,
  output logic                 core_return_from_irq,
  output int                   depth
);
  logic [PC_W-1:0] stk [DEPTH];
  assign core_boundary = 1'b1;
  assign stack_full    = (depth == DEPTH);
  always_ff @(posedge clk) begin
    if (rst) begin
      depth                <= 0;
      core_next_pc         <= '0;
      core_return_from_irq <= 1'b0;
    end else begin
      core_return_from_irq <= ret_req;
      if (stack_push) begin
        stk[depth]   <= stack_push_pc;
        depth        <= depth + 1;
        core_next_pc <= irq_vector;
      end else if (stack_pop && depth > 0) begin
        depth        <= depth - 1;
        core_next_pc <= stk[depth-1];
      end else begin
        core_next_pc <= core_next_pc + 1'b1;
      end
    end
  end
endmodule

// >>> testbench/test_mic_irq_ctrl.sv
// Purpose: Register-level test of the interrupt controller
// Assumes: Core model supplies next PC and the stack
// Notes:   Flags are raised by events or register writes
`timescale 1ns/1ps
module test_mic_irq_ctrl;
  import mic_pkg::*;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, ret_req;
  logic        awready, wready, bvalid, arready, rvalid, conv, take, push, pop, wake, bnd, full, rfi;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, pin, fsel, dir, stde, pere;
  logic [11:0] vec, ppc, npc, pc_q;
  int          error_cnt, check_count, take_cnt, wake_cnt, cyc, dep, base;

  mic_irq_ctrl mic_irq_ctrl_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin(pin), .pin_func_sel(fsel), .pin_dir_in(dir), .conv_done_evt(conv),
    .std_cmp_evt(stde), .per_cmp_evt(pere), .core_boundary(bnd), .core_next_pc(npc),
    .stack_full(full), .core_return_from_irq(rfi), .irq_take(take), .irq_vector(vec),
    .stack_push(push), .stack_push_pc(ppc), .stack_pop(pop), .wake(wake));

  mic_core_model mic_core_model_inst (
    .clk(clk), .rst(rst), .ret_req(ret_req), .stack_push(push), .stack_push_pc(ppc),
    .stack_pop(pop), .irq_vector(vec), .core_boundary(bnd), .core_next_pc(npc),
    .stack_full(full), .core_return_from_irq(rfi), .depth(dep));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    @(posedge clk);
    while (!(awready && wready)) @(posedge clk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (!bvalid) @(posedge clk);
    check("bresp", bresp, r);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] r = RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    check("rdata", rdata, {24'h0, exp});
    check("rresp", rresp, r);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ev(input logic [4:0] v);
    {conv, stde, pere} <= v;
    @(posedge clk);
    {conv, stde, pere} <= 5'h0;
    @(posedge clk);
  endtask

  task automatic got(input int n, input logic [11:0] v);
    repeat (20) if (take_cnt == n) @(posedge clk);
    check("take", take_cnt, n + 1);
    check("vector", vec, v);
  endtask

  task automatic idle(input int n);
    repeat (6) @(posedge clk);
    check("take", take_cnt, n);
  endtask

  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic clr();
    wr(OFS_STD, 8'h00);
    wr(OFS_PER, 8'h00);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc   <= cyc + 1;
    pc_q  <= npc;
    if (take === 1'b1) take_cnt <= take_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (take === 1'b1) check("push_pc", ppc, pc_q);
    if (!rst) check("push", push, take);
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, ret_req, conv} = 8'h80;
    {awaddr, araddr, wdata, pin, fsel, dir, stde, pere} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 5; a++) rd(8'(4 * a), 8'h00);
    rd(8'h20, 8'h00, RESP_SLVERR);
    wr(8'h20, 8'hff, RESP_SLVERR);
    wr(OFS_STD, 8'hff);
    rd(OFS_STD, 8'h33);
    wr(OFS_PER, 8'hff);
    rd(OFS_PER, 8'h33);
    rd(OFS_CTRL0, 8'h60);
    clr();
    rd(OFS_CTRL0, 8'h00);
    base = wake_cnt;
    ev(5'b01000);
    rd(OFS_STD, 8'h20);
    rd(OFS_CTRL0, 8'h20);
    check("wake", wake_cnt, base + 1);
    ev(5'b00001);
    rd(OFS_PER, 8'h10);
    rd(OFS_CTRL0, 8'h60);
    base = take_cnt;
    wr(OFS_STD, 8'h22);
    wr(OFS_CTRL0, 8'h64);
    idle(base);
    wr(OFS_CTRL0, 8'h65);
    got(base, 12'h00c);
    rd(OFS_CTRL0, 8'h44);
    rd(OFS_STD, 8'h22);
    check("depth", dep, 1);
    ret();
    rd(OFS_CTRL0, 8'h45);
    check("depth", dep, 0);
    wr(OFS_CTRL0, 8'h4d);
    idle(base + 1);
    wr(OFS_PER, 8'h11);
    got(base + 1, 12'h010);
    rd(OFS_PER, 8'h11);
    ret();
    clr();
    wr(OFS_CTRL1, 8'hcc);
    wr(OFS_CTRL0, 8'h12);
    base = take_cnt;
    wr(OFS_CTRL0, 8'h13);
    got(base, 12'h004);
    rd(OFS_CTRL0, 8'h02);
    ret();
    got(base + 1, 12'h008);
    ret();
    got(base + 2, 12'h014);
    rd(OFS_CTRL1, 8'h0c);
    ret();
    base = take_cnt;
    wr(OFS_CTRL1, 8'h8c);
    got(base, 12'h014);
    wr(OFS_CTRL1, 8'h4c);
    wr(OFS_CTRL0, 8'h03);
    got(base + 1, 12'h008);
    wr(OFS_CTRL1, 8'h8c);
    wr(OFS_CTRL0, 8'h03);
    idle(base + 2);
    ret();
    got(base + 2, 12'h014);
    ret();
    ret();
    check("depth", dep, 0);
    base = take_cnt;
    ev(5'b10000);
    got(base, 12'h014);
    rd(OFS_CTRL1, 8'h0c);
    ret();
    clr();
    fsel <= 2'b11;
    dir  <= 2'b11;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE, 8'(c));
      for (int e = 0; e < 2; e++) begin
        pin[0] <= ~pin[0];
        repeat (6) @(posedge clk);
        rd(OFS_CTRL0, {3'h0, c == 3 || c == e + 1, 4'h0});
        wr(OFS_CTRL0, 8'h00);
      end
    end
    wr(OFS_EDGE, 8'h0f);
    for (int m = 1; m < 3; m++) begin
      {fsel[0], dir[0]} <= 2'(m);
      pin[0] <= ~pin[0];
      repeat (6) @(posedge clk);
      rd(OFS_CTRL0, 8'h00);
    end
    pin[1] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFS_CTRL1, 8'h40);
    report_and_stop();
  end
endmodule
